// file: core/dcwd_pkg.sv
/*
  dcwd_pkg: bit positions, reset values and selector codes of the drive
  command word decoder.
  Assumes: shared by the decoder top, its gate module and the gate interface.
*/
package dcwd_pkg;

  localparam int unsigned WORD_W = 16;

  // bit positions inside drive_command_word
  localparam int unsigned BIT_PRESET_LSB = 0;
  localparam int unsigned BIT_PRESET_MSB = 1;
  localparam int unsigned BIT_DC_BRAKE_N = 2;
  localparam int unsigned BIT_COAST_N = 3;
  localparam int unsigned BIT_QSTOP_N = 4;
  localparam int unsigned BIT_HOLD_N = 5;
  localparam int unsigned BIT_START = 6;
  localparam int unsigned BIT_TRIP_RESET = 7;
  localparam int unsigned BIT_JOG = 8;
  localparam int unsigned BIT_RAMP2 = 9;
  localparam int unsigned BIT_DATA_VALID = 10;
  localparam int unsigned BIT_RELAY1 = 11;
  localparam int unsigned BIT_RELAY2 = 12;
  localparam int unsigned BIT_SETUP_LSB = 13;
  localparam int unsigned BIT_SETUP_MSB = 14;
  localparam int unsigned BIT_REVERSE = 15;

  // all zero: coast, dc brake and frequency hold active until a word arrives
  localparam logic [15:0] WORD_RST = 16'h0000;

  // lanes that are combined with digital inputs
  localparam int unsigned LANES = 7;
  localparam int unsigned LANE_PRESET0 = 0;
  localparam int unsigned LANE_PRESET1 = 1;
  localparam int unsigned LANE_COAST = 2;
  localparam int unsigned LANE_START = 3;
  localparam int unsigned LANE_SETUP0 = 4;
  localparam int unsigned LANE_SETUP1 = 5;
  localparam int unsigned LANE_REVERSE = 6;

  // digital input pins, in the order of the din port
  localparam int unsigned DIN_W = 11;
  localparam int unsigned DIN_PRESET0 = 0;
  localparam int unsigned DIN_PRESET1 = 1;
  localparam int unsigned DIN_COAST = 2;
  localparam int unsigned DIN_START = 3;
  localparam int unsigned DIN_SETUP0 = 4;
  localparam int unsigned DIN_SETUP1 = 5;
  localparam int unsigned DIN_REVERSE = 6;
  localparam int unsigned DIN_DC_BRAKE = 7;
  localparam int unsigned DIN_RESET_COAST = 8;
  localparam int unsigned DIN_SPEED_UP = 9;
  localparam int unsigned DIN_SLOW_DOWN = 10;

  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [1:0] SETUP_RST = 2'h0;
  localparam logic [1:0] PRESET_RST = 2'h0;

  // per-function source selector
  typedef enum logic [1:0] {
    DCWD_SRC_DIGITAL,
    DCWD_SRC_SERIAL,
    DCWD_SRC_AND,
    DCWD_SRC_OR
  } dcwd_src_t;

endpackage

// file: core/dcwd_gate_if.sv
/*
  dcwd_gate_if: carries bus-side and pin-side command lanes, their
  selectors and the gated result between decoder and gate.
  Assumes: purely combinational path, no clock of its own.
*/
`timescale 1ns/1ps
`default_nettype none

interface dcwd_gate_if;
  import dcwd_pkg::*;
  logic [LANES-1:0] bus_act;
  logic [LANES-1:0] pin_act;
  dcwd_src_t sel [LANES];
  logic [LANES-1:0] result;

  modport owner (output bus_act, output pin_act, output sel, input result);
  modport gate (input bus_act, input pin_act, input sel, output result);
endinterface

`default_nettype wire

// file: core/dcwd_gate.sv
/*
  dcwd_gate: combines each command lane of the word with its digital
  input under that lane's selector.
  Assumes: both lanes are active-high commands; driven from one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module dcwd_gate
  import dcwd_pkg::*;
(
  dcwd_gate_if.gate g
);

  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      wire logic b;
      wire logic p;
      assign b = g.bus_act[i];
      assign p = g.pin_act[i];
      assign g.result[i] = (g.sel[i] == DCWD_SRC_SERIAL) ? b :
                           (g.sel[i] == DCWD_SRC_AND) ? (b & p) :
                           (g.sel[i] == DCWD_SRC_OR) ? (b | p) : p;
    end
  endgenerate

endmodule

`default_nettype wire

// file: core/dcwd_decoder.sv
/*
  dcwd_decoder: holds the received drive command word and turns it into
  registered drive commands, merged with the drive's digital inputs.
  Assumes: word_in/word_wr come from the telegram layer on core_clk;
  din comes from pins and is synchronised here; settings are static-ish.
*/
// Notes on behaviour
// - bits 1:0 pick one of four preset references
// - bit 2 low: dc brake and stop; high: normal ramping
// - bit 3 low: output stage off, motor coasts; high: start allowed
// - bit 4 low: ramp down to stop on the quick-stop ramp
// - bit 5 low: hold output frequency; only speed-up/slow-down inputs move it
// - while held, only coast, dc brake or matching inputs stop the motor
// - bit 6 low: ramp stop on selected ramp; high: start permitted
// - trip reset only on rising edge of bit 7
// - bit 8 high: output frequency from inching speed setting
// - bit 9 selects ramp pair one or two
// - bit 10 low: whole word ignored; high: word used
// - bit 11 drives relay one when its function selects this bit
// - bit 12 drives relay two when its function selects this bit
// - bits 14:13 select parameter set-up one to four
// - set-up selection honoured only in multiple set-ups mode
// - bit 15 reverses only for serial, logic or, logic and sources
// - preset, coast, start, set-up, reverse gated with inputs per selector
`timescale 1ns/1ps
`default_nettype none

module dcwd_decoder
  import dcwd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // command word from the telegram layer, same clock
  input wire logic [dcwd_pkg::WORD_W-1:0] word_in,
  input wire logic word_wr,
  // digital input pins, asynchronous, active high
  input wire logic [dcwd_pkg::DIN_W-1:0] din,
  // function selectors
  input wire dcwd_pkg::dcwd_src_t preset_src,
  input wire dcwd_pkg::dcwd_src_t coast_src,
  input wire dcwd_pkg::dcwd_src_t start_src,
  input wire dcwd_pkg::dcwd_src_t setup_src,
  input wire dcwd_pkg::dcwd_src_t reverse_src,
  input wire logic relay1_uses_word,
  input wire logic relay2_uses_word,
  input wire logic multi_setup_mode,
  // drive commands
  output logic [1:0] preset_idx,
  output logic dc_brake,
  output logic coast,
  output logic quick_stop,
  output logic freq_hold,
  output logic freq_up,
  output logic freq_down,
  output logic ramp_stop,
  output logic run_enable,
  output logic trip_reset,
  output logic inching,
  output logic ramp2_sel,
  output logic relay1,
  output logic relay2,
  output logic [1:0] setup_sel,
  output logic reverse,
  output logic [dcwd_pkg::WORD_W-1:0] word_held
);

  logic [WORD_W-1:0] word_r;
  logic [DIN_W-1:0] sync1_r;
  logic [DIN_W-1:0] sync2_r;
  logic [DIN_W-1:0] sync3_r;
  wire logic [DIN_W-1:0] din_r;
  logic trip_prev_r;

  logic [1:0] preset_r;
  logic dc_brake_r;
  logic coast_r;
  logic qstop_r;
  logic hold_r;
  logic up_r;
  logic down_r;
  logic ramp_stop_r;
  logic run_r;
  logic trip_reset_r;
  logic inching_r;
  logic ramp2_r;
  logic relay1_r;
  logic relay2_r;
  logic [1:0] setup_r;
  logic reverse_r;

  // package layout guards; the lanes and the pin path are built for these
  if (WORD_W != 16) begin : g_chk_word
    $error("drive command word must be 16 bits wide");
  end
  if (BIT_REVERSE >= WORD_W || BIT_SETUP_MSB >= WORD_W) begin : g_chk_bits
    $error("command bit position beyond the word");
  end
  if (LANES != 7) begin : g_chk_lanes
    $error("gate lanes do not match the decoded functions");
  end
  if (DIN_SLOW_DOWN >= DIN_W || DIN_RESET_COAST >= DIN_W) begin : g_chk_pins
    $error("pin position beyond the din port");
  end
  if (SYNC_STAGES != 3) begin : g_chk_sync
    $error("pin path is built for exactly three stages");
  end

  dcwd_gate_if gif ();

  wire logic word_take;
  assign word_take = word_wr & word_in[BIT_DATA_VALID];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_r <= WORD_RST;
    end else if (ce && word_take) begin
      word_r <= word_in;
    end
  end

  // three-stage pin synchroniser; a change counts once stages 2 and 3 agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else if (ce) begin
      sync1_r <= din;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  genvar k;
  generate
    for (k = 0; k < DIN_W; k++) begin : g_din
      logic q_r;
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          q_r <= 1'b0;
        end else if (ce && (sync2_r[k] == sync3_r[k])) begin
          q_r <= sync3_r[k];
        end
      end
      // one flop per pin keeps each lane a single driver
      assign din_r[k] = q_r;
    end
  endgenerate

  // active-high command lanes; coast is inverted since bit 3 low coasts
  assign gif.bus_act[LANE_PRESET0] = word_r[BIT_PRESET_LSB];
  assign gif.bus_act[LANE_PRESET1] = word_r[BIT_PRESET_MSB];
  assign gif.bus_act[LANE_COAST] = ~word_r[BIT_COAST_N];
  assign gif.bus_act[LANE_START] = word_r[BIT_START];
  assign gif.bus_act[LANE_SETUP0] = word_r[BIT_SETUP_LSB];
  assign gif.bus_act[LANE_SETUP1] = word_r[BIT_SETUP_MSB];
  assign gif.bus_act[LANE_REVERSE] = word_r[BIT_REVERSE];

  assign gif.pin_act[LANE_PRESET0] = din_r[DIN_PRESET0];
  assign gif.pin_act[LANE_PRESET1] = din_r[DIN_PRESET1];
  assign gif.pin_act[LANE_COAST] = din_r[DIN_COAST];
  assign gif.pin_act[LANE_START] = din_r[DIN_START];
  assign gif.pin_act[LANE_SETUP0] = din_r[DIN_SETUP0];
  assign gif.pin_act[LANE_SETUP1] = din_r[DIN_SETUP1];
  assign gif.pin_act[LANE_REVERSE] = din_r[DIN_REVERSE];

  assign gif.sel[LANE_PRESET0] = preset_src;
  assign gif.sel[LANE_PRESET1] = preset_src;
  assign gif.sel[LANE_COAST] = coast_src;
  assign gif.sel[LANE_START] = start_src;
  assign gif.sel[LANE_SETUP0] = setup_src;
  assign gif.sel[LANE_SETUP1] = setup_src;
  // digital selector keeps bit 15 out of the result
  assign gif.sel[LANE_REVERSE] = reverse_src;

  dcwd_gate u_gate (
    .g (gif.gate)
  );

  // decoded next values
  wire logic hold_nxt;
  wire logic dcb_nxt;
  wire logic coast_nxt;
  wire logic qstop_nxt;
  wire logic rstop_nxt;
  wire logic run_nxt;
  wire logic trip_nxt;
  wire logic [1:0] setup_nxt;
  wire logic [1:0] preset_nxt;
  wire logic up_nxt;
  wire logic down_nxt;
  wire logic relay1_nxt;
  wire logic relay2_nxt;
  wire logic reverse_nxt;

  assign hold_nxt = ~word_r[BIT_HOLD_N];
  assign dcb_nxt = ~word_r[BIT_DC_BRAKE_N] | din_r[DIN_DC_BRAKE];
  assign coast_nxt = gif.result[LANE_COAST] | din_r[DIN_RESET_COAST];
  // quick stop is not accepted while frequency is held
  assign qstop_nxt = ~word_r[BIT_QSTOP_N] & ~hold_nxt;
  assign rstop_nxt = ~gif.result[LANE_START] & ~hold_nxt;
  // a held drive keeps running until coast or dc brake
  assign run_nxt = ~coast_nxt & ~dcb_nxt & ~qstop_nxt & ~rstop_nxt;
  assign trip_nxt = word_r[BIT_TRIP_RESET] & ~trip_prev_r;
  // outside multi set-up mode the last choice stays
  assign setup_nxt = multi_setup_mode ?
                     {gif.result[LANE_SETUP1], gif.result[LANE_SETUP0]} :
                     setup_r;

  assign preset_nxt = {gif.result[LANE_PRESET1], gif.result[LANE_PRESET0]};
  // only the speed inputs move a held frequency
  assign up_nxt = hold_nxt & din_r[DIN_SPEED_UP];
  assign down_nxt = hold_nxt & din_r[DIN_SLOW_DOWN];
  // a relay set to another function ignores its bit
  assign relay1_nxt = word_r[BIT_RELAY1] & relay1_uses_word;
  assign relay2_nxt = word_r[BIT_RELAY2] & relay2_uses_word;
  assign reverse_nxt = gif.result[LANE_REVERSE];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trip_prev_r <= 1'b0;
      trip_reset_r <= 1'b0;
    end else if (ce) begin
      trip_prev_r <= word_r[BIT_TRIP_RESET];
      trip_reset_r <= trip_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      preset_r <= PRESET_RST;
      dc_brake_r <= 1'b1;
      coast_r <= 1'b1;
      qstop_r <= 1'b0;
      hold_r <= 1'b0;
      up_r <= 1'b0;
      down_r <= 1'b0;
      ramp_stop_r <= 1'b0;
      run_r <= 1'b0;
    end else if (ce) begin
      preset_r <= preset_nxt;
      dc_brake_r <= dcb_nxt;
      coast_r <= coast_nxt;
      qstop_r <= qstop_nxt;
      hold_r <= hold_nxt;
      // only the speed inputs move a held frequency
      up_r <= up_nxt;
      down_r <= down_nxt;
      ramp_stop_r <= rstop_nxt;
      run_r <= run_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inching_r <= 1'b0;
      ramp2_r <= 1'b0;
      relay1_r <= 1'b0;
      relay2_r <= 1'b0;
      setup_r <= SETUP_RST;
      reverse_r <= 1'b0;
    end else if (ce) begin
      inching_r <= word_r[BIT_JOG];
      ramp2_r <= word_r[BIT_RAMP2];
      relay1_r <= relay1_nxt;
      relay2_r <= relay2_nxt;
      setup_r <= setup_nxt;
      reverse_r <= reverse_nxt;
    end
  end

  assign preset_idx = preset_r;
  assign dc_brake = dc_brake_r;
  assign coast = coast_r;
  assign quick_stop = qstop_r;
  assign freq_hold = hold_r;
  assign freq_up = up_r;
  assign freq_down = down_r;
  assign ramp_stop = ramp_stop_r;
  assign run_enable = run_r;
  assign trip_reset = trip_reset_r;
  assign inching = inching_r;
  assign ramp2_sel = ramp2_r;
  assign relay1 = relay1_r;
  assign relay2 = relay2_r;
  assign setup_sel = setup_r;
  assign reverse = reverse_r;
  assign word_held = word_r;

endmodule

`default_nettype wire

// file: bench/dcwd_checker.sv
/*
  dcwd_checker: port-level assertions for the drive command word decoder.
  Assumes one clock, core_clk, and an asynchronous active-high rst.
*/
`timescale 1ns/1ps
`default_nettype none

module dcwd_checker
  import dcwd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [dcwd_pkg::WORD_W-1:0] word_in,
  input wire logic word_wr,
  input wire logic [dcwd_pkg::WORD_W-1:0] word_held,
  input wire logic relay1_uses_word,
  input wire logic multi_setup_mode,
  input wire logic dc_brake,
  input wire logic coast,
  input wire logic quick_stop,
  input wire logic freq_hold,
  input wire logic ramp_stop,
  input wire logic run_enable,
  input wire logic trip_reset,
  input wire logic inching,
  input wire logic ramp2_sel,
  input wire logic relay1,
  input wire logic [1:0] setup_sel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_take;
    ce && word_wr && word_in[BIT_DATA_VALID];
  endsequence

  a_word_capture: assert property (s_take |=> word_held == $past(word_in))
    else $error("held word differs from taken word");
  a_invalid_ignored: assert property (
    !(ce && word_wr && word_in[BIT_DATA_VALID]) |=> $stable(word_held))
    else $error("held word changed without a valid write");
  a_trip_rise: assert property (ce && $rose(word_held[7]) |=> trip_reset)
    else $error("no trip reset pulse on rising bit");
  a_trip_single: assert property (ce && trip_reset |=> !trip_reset)
    else $error("trip reset longer than one cycle");
  a_brake_low: assert property (ce && !word_held[2] |=> dc_brake)
    else $error("dc brake missing for cleared bit");
  a_run_gate: assert property (
    run_enable |-> !(coast || dc_brake || quick_stop || ramp_stop))
    else $error("run enabled while a stop is active");
  a_relay_one: assert property (
    ce |=> relay1 == ($past(word_held[11]) && $past(relay1_uses_word)))
    else $error("relay one does not follow word and function");
  a_jog_ramp: assert property (
    ce |=> {ramp2_sel, inching} == $past(word_held[9:8]))
    else $error("inching or ramp pair select wrong");
  a_hold_decode: assert property (ce |=> freq_hold == !$past(word_held[5]))
    else $error("frequency hold does not follow word");
  a_hold_stops: assert property (freq_hold |-> !quick_stop && !ramp_stop)
    else $error("ramped stop accepted while frequency held");
  a_setup_keep: assert property (ce && !multi_setup_mode |=> $stable(setup_sel))
    else $error("set-up changed outside multi set-up mode");
endmodule

bind dcwd_decoder dcwd_checker u_chk (
  .core_clk(core_clk), .rst(rst), .ce(ce), .word_in(word_in),
  .word_wr(word_wr), .word_held(word_held),
  .relay1_uses_word(relay1_uses_word), .multi_setup_mode(multi_setup_mode),
  .dc_brake(dc_brake), .coast(coast), .quick_stop(quick_stop),
  .freq_hold(freq_hold), .ramp_stop(ramp_stop), .run_enable(run_enable),
  .trip_reset(trip_reset), .inching(inching), .ramp2_sel(ramp2_sel),
  .relay1(relay1), .setup_sel(setup_sel));

`default_nettype wire

// file: bench/dcwd_master_model.sv
/*
  dcwd_master_model: fieldbus master handing command words to the decoder.
  Assumes send is called just after a falling edge of core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module dcwd_master_model
  import dcwd_pkg::*;
(
  input wire logic core_clk,
  output logic [dcwd_pkg::WORD_W-1:0] word_in,
  output logic word_wr
);
  initial begin
    word_in = 16'h0000;
    word_wr = 1'b0;
  end

  // caller sets the valid bit only on words meant to act
  task automatic send(input logic [15:0] w);
    word_in = w;
    word_wr = 1'b1;
    @(negedge core_clk);
    word_wr = 1'b0;
    // released bus must not keep showing the old word
    word_in = ~w;
  endtask
endmodule

`default_nettype wire

// file: bench/tb_top.sv
/*
  tb_top: directed test of the drive command word decoder.
  Assumes the master model and all bench inputs move on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import dcwd_pkg::*;
  logic core_clk, rst, ce, relay1_uses_word, relay2_uses_word, multi_setup_mode;
  wire logic [WORD_W-1:0] word_in;
  wire logic word_wr;
  logic [WORD_W-1:0] word_held, lw;
  logic [DIN_W-1:0] din;
  dcwd_src_t preset_src, coast_src, start_src, setup_src, reverse_src;
  logic [1:0] preset_idx, setup_sel;
  logic dc_brake, coast, quick_stop, freq_hold, freq_up, freq_down, ramp_stop;
  logic run_enable, trip_reset, inching, ramp2_sel, relay1, relay2, reverse;
  wire logic [15:0] outs;
  int miscompares = 0;
  int cmp_count = 0;
  localparam logic [15:0] BASE = 16'h047C;
  logic [15:0] tbl [8] = '{16'h047C, 16'h0478, 16'h0474, 16'h046C,
    16'h044C, 16'h041C, 16'h043C, 16'h9F7C};

  assign outs = {5'h00, dc_brake, coast, quick_stop, freq_hold, ramp_stop,
    run_enable, inching, ramp2_sel, relay1, relay2, reverse};

  dcwd_master_model master (.core_clk(core_clk), .word_in(word_in),
    .word_wr(word_wr));
  dcwd_decoder dut (.core_clk(core_clk), .rst(rst), .ce(ce),
    .word_in(word_in), .word_wr(word_wr), .din(din),
    .preset_src(preset_src), .coast_src(coast_src), .start_src(start_src),
    .setup_src(setup_src), .reverse_src(reverse_src),
    .relay1_uses_word(relay1_uses_word), .relay2_uses_word(relay2_uses_word),
    .multi_setup_mode(multi_setup_mode), .preset_idx(preset_idx),
    .dc_brake(dc_brake), .coast(coast), .quick_stop(quick_stop),
    .freq_hold(freq_hold), .freq_up(freq_up), .freq_down(freq_down),
    .ramp_stop(ramp_stop), .run_enable(run_enable), .trip_reset(trip_reset),
    .inching(inching), .ramp2_sel(ramp2_sel), .relay1(relay1),
    .relay2(relay2), .setup_sel(setup_sel), .reverse(reverse),
    .word_held(word_held));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // expected outputs with all pins idle and serial selectors
  function automatic logic [15:0] expo(logic [15:0] w, logic u);
    logic h, dc, co, qs, rs;
    h = ~w[5];
    dc = ~w[2];
    co = ~w[3];
    qs = ~w[4] & ~h;
    rs = ~w[6] & ~h;
    return {5'h00, dc, co, qs, h, rs, ~(dc | co | qs | rs), w[8], w[9],
      w[11] & u, w[12] & u, w[15]};
  endfunction

  task automatic apply(logic [15:0] w);
    master.send(w);
    @(negedge core_clk);
  endtask

  task automatic done(string n);
    $display("test %s finished", n);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    din = '0;
    multi_setup_mode = 1'b1;
    relay1_uses_word = 1'b1;
    relay2_uses_word = 1'b1;
    preset_src = DCWD_SRC_SERIAL;
    coast_src = DCWD_SRC_SERIAL;
    start_src = DCWD_SRC_SERIAL;
    setup_src = DCWD_SRC_SERIAL;
    reverse_src = DCWD_SRC_SERIAL;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    chk("held", 16'h0000, word_held);
    chk("outs", 16'h0600, outs);
    chk("sel", 16'h0000, {12'h000, preset_idx, setup_sel});
    done("reset");
    foreach (tbl[i]) begin
      apply(tbl[i]);
      chk("held", tbl[i], word_held);
      chk("outs", expo(tbl[i], 1'b1), outs);
    end
    done("decode");
    for (int i = 0; i < 4; i++) begin
      lw = BASE | 16'(i) | (16'(i) << 13);
      apply(lw);
      chk("preset", 16'(i), {14'h0000, preset_idx});
      chk("setup", 16'(i), {14'h0000, setup_sel});
    end
    multi_setup_mode = 1'b0;
    apply(BASE);
    chk("setup", 16'h0003, {14'h0000, setup_sel});
    multi_setup_mode = 1'b1;
    done("select");
    lw = word_held;
    apply(16'h007C);
    chk("held", lw, word_held);
    ce = 1'b0;
    apply(BASE | 16'h0300);
    ce = 1'b1;
    chk("held", lw, word_held);
    chk("outs", 16'h0020, outs);
    done("ignore");
    apply(BASE | 16'h0080);
    chk("trip", 16'h0001, {15'h0000, trip_reset});
    @(negedge core_clk);
    chk("trip", 16'h0000, {15'h0000, trip_reset});
    apply(BASE | 16'h0080);
    chk("trip", 16'h0000, {15'h0000, trip_reset});
    done("trip");
    relay1_uses_word = 1'b0;
    relay2_uses_word = 1'b0;
    apply(16'h9F7C);
    chk("outs", expo(16'h9F7C, 1'b0), outs);
    done("relay");
    reverse_src = DCWD_SRC_DIGITAL;
    apply(16'h847C);
    chk("reverse", 16'h0000, {15'h0000, reverse});
    din[DIN_REVERSE] = 1'b1;
    preset_src = DCWD_SRC_AND;
    din[1:0] = 2'b01;
    repeat (6) @(negedge core_clk);
    chk("reverse", 16'h0001, {15'h0000, reverse});
    apply(BASE | 16'h0003);
    chk("preset", 16'h0001, {14'h0000, preset_idx});
    done("gating");
    apply(16'h044C);
    din[DIN_SPEED_UP] = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("up", 16'h0001, {15'h0000, freq_up});
    chk("down", 16'h0000, {15'h0000, freq_down});
    chk("outs", 16'h00A1, outs);
    done("hold");
    din[DIN_DC_BRAKE] = 1'b1;
    din[DIN_SLOW_DOWN] = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("down", 16'h0001, {15'h0000, freq_down});
    chk("outs", 16'h0481, outs);
    din[DIN_DC_BRAKE] = 1'b0;
    coast_src = DCWD_SRC_OR;
    din[DIN_COAST] = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("outs", 16'h0281, outs);
    din[DIN_COAST] = 1'b0;
    din[DIN_SETUP1] = 1'b1;
    setup_src = DCWD_SRC_DIGITAL;
    start_src = DCWD_SRC_AND;
    apply(BASE);
    repeat (6) @(negedge core_clk);
    chk("outs", 16'h0041, outs);
    chk("up", 16'h0000, {15'h0000, freq_up});
    chk("setup", 16'h0002, {14'h0000, setup_sel});
    done("pins");
    summarize();
  end
endmodule

`default_nettype wire
